// ==== hw/vnic_defs.vh ====
// register offsets, field positions and reset values of the interrupt block
`ifndef VNIC_DEFS_VH
`define VNIC_DEFS_VH
`define VNIC_NSTA_ADDR 32'hffff0000
`define VNIC_NSIG_ADDR 32'hffff0004
`define VNIC_NEN_ADDR 32'hffff0008
`define VNIC_NCLR_ADDR 32'hffff000c
`define VNIC_NVEC_ADDR 32'hffff001c
`define VNIC_NPRI_ADDR 32'hffff0080
`define VNIC_CONN_ADDR 32'hffff0030
`define VNIC_NLVL_ADDR 32'hffff003c
`define VNIC_BASE_ADDR 32'hffff0040
`define VNIC_FSTA_ADDR 32'hffff0100
`define VNIC_FSIG_ADDR 32'hffff0104
`define VNIC_FEN_ADDR 32'hffff0108
`define VNIC_FCLR_ADDR 32'hffff010c
`define VNIC_FVEC_ADDR 32'hffff011c
`define VNIC_FLVL_ADDR 32'hffff013c
`define VNIC_PRI_STRIDE 32'h00000004
`define VNIC_NEST_IRQ_BIT 0
`define VNIC_NEST_FIQ_BIT 1
`define VNIC_VEC_BASE_LSB 7
`define VNIC_VEC_IDX_LSB 2
`define VNIC_CONN_RESET 2'h0
`define VNIC_LVL_RESET 8'h00
`endif

// ==== hw/vnic_top.v ====
// vectored nesting interrupt controller with normal and fast request lines
`timescale 1ns/1ps
`include "vnic_defs.vh"
module vnic_top #(
   parameter NSRC = 22
) (
   clk,
   rst_n,
   src_level,
   bus_addr,
   bus_wdata,
   bus_wr,
   bus_rd,
   bus_rdata,
   irq_out,
   fiq_out
);
   input wire clk;
   input wire rst_n;
   input wire [NSRC-1:1] src_level;
   input wire [31:0] bus_addr;
   input wire [31:0] bus_wdata;
   input wire bus_wr;
   input wire bus_rd;
   output reg [31:0] bus_rdata;
   output reg irq_out;
   output reg fiq_out;

   // ==========================================================
   // registers
   reg [NSRC-1:1] n_en;
   reg [NSRC-1:1] f_en;
   reg [1:0] conn;
   reg [7:0] n_lvl;
   reg [7:0] f_lvl;
   reg [15:0] vbase;
   wire [3*NSRC-1:0] pri;
   reg [NSRC-1:1] raw;

   // ==========================================================
   // pending and priority resolution
   wire [NSRC-1:1] n_pend = raw & n_en;
   wire [NSRC-1:1] f_pend = raw & f_en;
   wire f_any = |f_pend;
   wire [31:0] f_sta = {{(32-NSRC){1'b0}}, f_pend, f_any};
   wire [31:0] n_sta = {{(32-NSRC){1'b0}}, n_pend, 1'b0};

   reg [4:0] n_idx;
   reg [2:0] n_ip;
   reg n_hit;
   reg [4:0] f_idx;
   reg [2:0] f_ip;
   reg f_hit;
   reg [2:0] p;
   integer i;

   // lowest level number is most urgent; a set level bit blocks it and
   // everything below it
   function lvl_open;
      input [7:0] lvl;
      input [2:0] pv;
      integer k;
      begin
         lvl_open = 1'b1;
         for (k = 0; k < 8; k = k + 1) begin
            if (lvl[k] && (pv >= k[2:0])) begin
               lvl_open = 1'b0;
            end
         end
      end
   endfunction

   always @* begin
      n_idx = 5'h00;
      n_ip = 3'h7;
      n_hit = 1'b0;
      f_idx = 5'h00;
      f_ip = 3'h7;
      f_hit = 1'b0;
      p = 3'h0;
      for (i = NSRC-1; i >= 1; i = i - 1) begin
         p = pri[3*i +: 3];
         if (n_pend[i] && lvl_open(n_lvl, p) &&
             (!n_hit || p <= n_ip)) begin
            n_hit = 1'b1;
            n_ip = p;
            n_idx = i[4:0];
         end
         if (f_pend[i] && lvl_open(f_lvl, p) &&
             (!f_hit || p <= f_ip)) begin
            f_hit = 1'b1;
            f_ip = p;
            f_idx = i[4:0];
         end
      end
   end

   // highest set level bit is the lowest index
   function [7:0] clr_top;
      input [7:0] lvl;
      integer k;
      reg done;
      begin
         clr_top = lvl;
         done = 1'b0;
         for (k = 0; k < 8; k = k + 1) begin
            if (!done && lvl[k]) begin
               clr_top[k] = 1'b0;
               done = 1'b1;
            end
         end
      end
   endfunction

   // ==========================================================
   // mode bits and vector words
   wire n_nest;
   wire f_nest;
   wire [31:0] n_vec;
   wire [31:0] f_vec;
   wire n_any;
   assign n_nest = conn[`VNIC_NEST_IRQ_BIT];
   assign f_nest = conn[`VNIC_NEST_FIQ_BIT];
   // nine zero bits on top, base, source index, two zero bits
   assign n_vec = {9'h000, vbase, n_idx, 2'h0};
   assign f_vec = {9'h000, vbase, f_idx, 2'h0};
   assign n_any = |n_sta;

   // ==========================================================
   // address decode
   wire sel_nen;
   wire sel_nclr;
   wire sel_nvec;
   wire sel_conn;
   wire sel_nlvl;
   wire sel_base;
   wire sel_fen;
   wire sel_fclr;
   wire sel_fvec;
   wire sel_flvl;
   assign sel_nen = (bus_addr == `VNIC_NEN_ADDR);
   assign sel_nclr = (bus_addr == `VNIC_NCLR_ADDR);
   assign sel_nvec = (bus_addr == `VNIC_NVEC_ADDR);
   assign sel_conn = (bus_addr == `VNIC_CONN_ADDR);
   assign sel_nlvl = (bus_addr == `VNIC_NLVL_ADDR);
   assign sel_base = (bus_addr == `VNIC_BASE_ADDR);
   assign sel_fen = (bus_addr == `VNIC_FEN_ADDR);
   assign sel_fclr = (bus_addr == `VNIC_FCLR_ADDR);
   assign sel_fvec = (bus_addr == `VNIC_FVEC_ADDR);
   assign sel_flvl = (bus_addr == `VNIC_FLVL_ADDR);

   // ==========================================================
   // write strobes and level stack pushes
   wire wr_nen;
   wire wr_nclr;
   wire wr_fen;
   wire wr_fclr;
   wire wr_conn;
   wire wr_base;
   wire wr_nlvl;
   wire wr_flvl;
   wire n_push;
   wire f_push;
   assign wr_nen = bus_wr && sel_nen;
   assign wr_nclr = bus_wr && sel_nclr;
   assign wr_fen = bus_wr && sel_fen;
   assign wr_fclr = bus_wr && sel_fclr;
   assign wr_conn = bus_wr && sel_conn;
   assign wr_base = bus_wr && sel_base;
   assign wr_nlvl = bus_wr && sel_nlvl;
   assign wr_flvl = bus_wr && sel_flvl;
   // a vector read only pushes while nesting is on and a source waits
   assign n_push = bus_rd && sel_nvec && n_nest && n_hit;
   assign f_push = bus_rd && sel_fvec && f_nest && f_hit;

   // ==========================================================
   // per-source priority fields, three bits each, 0 most urgent
   wire [NSRC-1:1] pri_hit;
   genvar g;
   // slot 0 has no source behind it
   assign pri[2:0] = 3'h0;
   generate
      for (g = 1; g < NSRC; g = g + 1) begin : src_slot
         wire [31:0] slot_addr;
         reg [2:0] level;
         assign slot_addr = `VNIC_NPRI_ADDR + `VNIC_PRI_STRIDE * g;
         assign pri_hit[g] = (bus_addr == slot_addr);
         assign pri[3*g +: 3] = level;
         always @(posedge clk) begin
            if (!rst_n) begin
               level <= 3'h0;
            end else if (bus_wr && pri_hit[g]) begin
               level <= bus_wdata[2:0];
            end
         end
      end
   endgenerate

   // ==========================================================
   // priority read back
   reg [2:0] pri_rd;
   integer i_rd;
   always @* begin
      pri_rd = 3'h0;
      for (i_rd = 1; i_rd < NSRC; i_rd = i_rd + 1) begin
         if (pri_hit[i_rd]) begin
            pri_rd = pri[3*i_rd +: 3];
         end
      end
   end

   // ==========================================================
   // read data select
   reg [31:0] next_rdata;
   always @* begin
      next_rdata = 32'h00000000;
      case (bus_addr)
         `VNIC_NSTA_ADDR: next_rdata = n_sta;
         `VNIC_NSIG_ADDR: next_rdata = {{(32-NSRC){1'b0}}, raw, 1'b0};
         `VNIC_NEN_ADDR: next_rdata = {{(32-NSRC){1'b0}}, n_en, 1'b0};
         `VNIC_NVEC_ADDR: next_rdata = n_vec;
         `VNIC_CONN_ADDR: next_rdata = {30'h00000000, conn};
         `VNIC_NLVL_ADDR: next_rdata = {24'h000000, n_lvl};
         `VNIC_BASE_ADDR: next_rdata = {16'h0000, vbase};
         `VNIC_FSTA_ADDR: next_rdata = f_sta;
         `VNIC_FSIG_ADDR: next_rdata = {{(32-NSRC){1'b0}}, raw, 1'b0};
         `VNIC_FEN_ADDR: next_rdata = {{(32-NSRC){1'b0}}, f_en, 1'b0};
         `VNIC_FVEC_ADDR: next_rdata = f_vec;
         `VNIC_FLVL_ADDR: next_rdata = {24'h000000, f_lvl};
         default: next_rdata = {29'h00000000, pri_rd};
      endcase
   end

   // ==========================================================
   // source sampling, no mask applied here
   always @(posedge clk) begin
      if (!rst_n) begin
         raw <= {(NSRC-1){1'b0}};
      end else begin
         raw <= src_level;
      end
   end

   // ==========================================================
   // normal mask: a one sets, a one in the clear word clears
   always @(posedge clk) begin
      if (!rst_n) begin
         n_en <= {(NSRC-1){1'b0}};
      end else if (wr_nen) begin
         n_en <= n_en | bus_wdata[NSRC-1:1];
      end else if (wr_nclr) begin
         n_en <= n_en & ~bus_wdata[NSRC-1:1];
      end
   end

   // ==========================================================
   // fast mask, same set and clear scheme
   always @(posedge clk) begin
      if (!rst_n) begin
         f_en <= {(NSRC-1){1'b0}};
      end else if (wr_fen) begin
         f_en <= f_en | bus_wdata[NSRC-1:1];
      end else if (wr_fclr) begin
         f_en <= f_en & ~bus_wdata[NSRC-1:1];
      end
   end

   // ==========================================================
   // nesting control
   always @(posedge clk) begin
      if (!rst_n) begin
         conn <= `VNIC_CONN_RESET;
      end else if (wr_conn) begin
         conn <= bus_wdata[1:0];
      end
   end

   // ==========================================================
   // vector base
   always @(posedge clk) begin
      if (!rst_n) begin
         vbase <= 16'h0000;
      end else if (wr_base) begin
         vbase <= bus_wdata[15:0];
      end
   end

   // ==========================================================
   // normal level stack: vector reads push, writes pop the top
   always @(posedge clk) begin
      if (!rst_n) begin
         n_lvl <= `VNIC_LVL_RESET;
      end else if (wr_nlvl) begin
         n_lvl <= clr_top(n_lvl);
      end else if (n_push) begin
         n_lvl <= n_lvl | (8'h01 << n_ip);
      end
   end

   // ==========================================================
   // fast level stack
   always @(posedge clk) begin
      if (!rst_n) begin
         f_lvl <= `VNIC_LVL_RESET;
      end else if (wr_flvl) begin
         f_lvl <= clr_top(f_lvl);
      end else if (f_push) begin
         f_lvl <= f_lvl | (8'h01 << f_ip);
      end
   end

   // ==========================================================
   // read data, zero outside the cycle after a read
   always @(posedge clk) begin
      if (!rst_n) begin
         bus_rdata <= 32'h00000000;
      end else if (bus_rd) begin
         bus_rdata <= next_rdata;
      end else begin
         bus_rdata <= 32'h00000000;
      end
   end

   // ==========================================================
   // request lines
   // basic mode: plain OR; nesting mode: gated by level status
   always @(posedge clk) begin
      if (!rst_n) begin
         irq_out <= 1'b0;
         fiq_out <= 1'b0;
      end else begin
         irq_out <= n_nest ? n_hit : n_any;
         fiq_out <= f_nest ? f_hit : f_any;
      end
   end
endmodule

// ==== tb/vnic_assertions.sv ====
// port checks for the interrupt block
`timescale 1ns/1ps
`include "vnic_defs.vh"
module vnic_assertions #(parameter NSRC = 22) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [NSRC-1:1] src_level,
   input wire logic [31:0] bus_addr,
   input wire logic [31:0] bus_wdata,
   input wire logic bus_wr,
   input wire logic bus_rd,
   input wire logic [31:0] bus_rdata,
   input wire logic irq_out,
   input wire logic fiq_out
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence rd_of(a);
      bus_rd && bus_addr == a;
   endsequence
   // ========
   // read data
   a_idle_zero: assert property (
      !bus_rd |=> bus_rdata == 0) else $error("idle read data");
   a_nsta_rsvd: assert property (
      rd_of(`VNIC_NSTA_ADDR) |=> bus_rdata[0] == 0 && bus_rdata[31:22] == 0)
      else $error("pending spare bits");
   a_raw_follow: assert property (
      rd_of(`VNIC_NSIG_ADDR) ##0 $stable(src_level)
      |=> bus_rdata[NSRC-1:1] == $past(src_level)) else $error("raw bits");
   a_conn_rsvd: assert property (
      rd_of(`VNIC_CONN_ADDR) |=> bus_rdata[31:2] == 0) else $error("conn");
   a_lvl_rsvd: assert property (
      rd_of(`VNIC_NLVL_ADDR) |=> bus_rdata[31:8] == 0) else $error("level");
   a_fvec_zero: assert property (
      rd_of(`VNIC_FVEC_ADDR) |=> bus_rdata[31:23] == 0 && bus_rdata[1:0] == 0)
      else $error("vector spare bits");
   // ========
   // request lines
   a_quiet_src: assert property (
      (src_level == 0) [*3] |=> !irq_out && !fiq_out) else $error("no source");
   a_reset_calm: assert property (
      $rose(rst_n) |-> !irq_out && !fiq_out && bus_rdata == 0)
      else $error("reset outputs");
endmodule

// ==== tb/vnic_core_model.sv ====
// processor core side: fast requests are taken before normal ones
`timescale 1ns/1ps
module vnic_core_model (
   input wire logic clk,
   input wire logic irq_out,
   input wire logic fiq_out,
   output logic [1:0] taken
);
   // 2 fast entry, 1 normal entry, 0 running
   always @(posedge clk) begin
      taken <= fiq_out ? 2'h2 : (irq_out ? 2'h1 : 2'h0);
   end
endmodule

// ==== tb/vnic_top_test.sv ====
// self-checking bench for the interrupt block
`timescale 1ns/1ps
`include "vnic_defs.vh"
module vnic_top_test;
   logic clk = 0, rst_n = 0, bus_wr = 0, bus_rd = 0;
   logic [21:1] src_level = 0;
   logic [31:0] bus_addr = 0, bus_wdata = 0, got;
   logic [15:0] base;
   wire [31:0] bus_rdata;
   wire irq_out, fiq_out;
   wire [1:0] taken;
   integer error_cnt = 0, total_checks = 0, seed = 2901, en = 0, v, i;
   always #2.5 clk = ~clk;
   vnic_top #(.NSRC(22)) vnic_top_inst (.clk(clk), .rst_n(rst_n),
      .src_level(src_level), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
      .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
      .irq_out(irq_out), .fiq_out(fiq_out));
   vnic_core_model vnic_core_model_inst (.clk(clk), .irq_out(irq_out),
      .fiq_out(fiq_out), .taken(taken));
   task complete_run;
      if (error_cnt == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value %s exp %h got %h", n, e, g);
      end
   endtask
   task wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      bus_addr <= a;
      bus_wdata <= d;
      bus_wr <= 1'b1;
      @(posedge clk);
      bus_wr <= 1'b0;
   endtask
   task rd(input logic [31:0] a, input logic [31:0] e);
      @(posedge clk);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge clk);
      bus_rd <= 1'b0;
      #1 got = bus_rdata;
      chk($sformatf("reg %h", a), e, got);
   endtask
   // ========
   // sequence
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      rd(`VNIC_NSTA_ADDR, 0);
      rd(`VNIC_CONN_ADDR, 0);
      rd(`VNIC_NLVL_ADDR, 0);
      rd(`VNIC_FVEC_ADDR, 0);
      rd(32'hffff0200, 0);
      for (i = 0; i < 6; i++) begin
         v = $random(seed) & 32'h3ffffe;
         wr(`VNIC_NEN_ADDR, v);
         en = en | v;
         v = $random(seed) & 32'h3ffffe;
         wr(`VNIC_NCLR_ADDR, v);
         en = en & ~v;
         src_level <= $random(seed);
         repeat (3) @(posedge clk);
         rd(`VNIC_NSIG_ADDR, {src_level, 1'b0});
         rd(`VNIC_NSTA_ADDR, {src_level, 1'b0} & en);
         chk("irq_out", |({src_level, 1'b0} & en), irq_out);
      end
      wr(`VNIC_NCLR_ADDR, 32'h3ffffe);
      wr(`VNIC_CONN_ADDR, 3);
      rd(`VNIC_CONN_ADDR, 3);
      src_level <= 21'h12;
      wr(`VNIC_NPRI_ADDR + 8, 3);
      wr(`VNIC_NPRI_ADDR + 20, 0);
      wr(`VNIC_NEN_ADDR, 32'h4);
      rd(`VNIC_NSTA_ADDR, 32'h4);
      rd(`VNIC_NVEC_ADDR, 32'h8);
      chk("irq_out", 1, irq_out);
      wr(`VNIC_NEN_ADDR, 32'h20);
      rd(`VNIC_NVEC_ADDR, 32'h14);
      rd(`VNIC_NVEC_ADDR, 32'h0);
      rd(`VNIC_NLVL_ADDR, 32'h9);
      chk("irq_out", 0, irq_out);
      wr(`VNIC_NLVL_ADDR, 32'hff);
      rd(`VNIC_NLVL_ADDR, 32'h8);
      chk("irq_out", 1, irq_out);
      wr(`VNIC_NLVL_ADDR, 32'hff);
      rd(`VNIC_NLVL_ADDR, 32'h0);
      base = $random(seed);
      wr(`VNIC_BASE_ADDR, base);
      wr(`VNIC_NCLR_ADDR, 32'h3ffffe);
      src_level <= 21'h8;
      wr(`VNIC_FEN_ADDR, 32'h10);
      repeat (3) @(posedge clk);
      chk("fiq_out", 1, fiq_out);
      chk("taken", 2, taken);
      rd(`VNIC_FVEC_ADDR, {9'h0, base, 5'h4, 2'h0});
      rd(`VNIC_FLVL_ADDR, 32'h1);
      chk("fiq_out", 0, fiq_out);
      wr(`VNIC_FLVL_ADDR, 32'h0);
      rd(`VNIC_FLVL_ADDR, 32'h0);
      complete_run;
   end
   initial begin
      #10000;
      error_cnt++;
      complete_run;
   end
endmodule
bind vnic_top vnic_assertions #(.NSRC(NSRC)) vnic_assertions_inst (
   .clk(clk), .rst_n(rst_n), .src_level(src_level), .bus_addr(bus_addr),
   .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
   .bus_rdata(bus_rdata), .irq_out(irq_out), .fiq_out(fiq_out));
